// [rtl/rphp_pkg.sv]
// Package for the root port hot-plug event block.
// Holds APB register offsets, field positions, reset values and carrier types.
package rphp_pkg;

  // Register byte offsets
  localparam logic [7:0] RPHP_CTRL_OFS   = 8'h00;  // Enables
  localparam logic [7:0] RPHP_STATUS_OFS = 8'h04;  // Sticky event bits, write one clears
  localparam logic [7:0] RPHP_INTSTS_OFS = 8'h08;  // Interrupt status, read clears
  localparam logic [7:0] RPHP_INTMSK_OFS = 8'h0C;  // Interrupt mask

  // Control field positions
  localparam int CTRL_PRES_IRQ_EN_BIT = 0;
  localparam int CTRL_HP_IRQ_EN_BIT   = 1;
  localparam int CTRL_SCI_EN_BIT      = 2;
  localparam int CTRL_SMI_EN_BIT      = 3;

  // Status field positions
  localparam int STS_PRES_STATE_BIT   = 0;
  localparam int STS_PRES_CHANGED_BIT = 1;
  localparam int STS_SCI_BIT          = 2;
  localparam int STS_SMI_PRES_BIT     = 3;
  localparam int STS_SMI_LINK_BIT     = 4;
  localparam int STS_LINK_ACTIVE_BIT  = 5;

  // Interrupt status field positions
  localparam int INT_PRES_BIT         = 0;
  localparam int INT_LINK_BIT         = 1;
  localparam int INT_WIDTH            = 2;

  // Reset values
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [INT_WIDTH-1:0] MASK_RESET = 2'h0;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // APB request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rphp_apb_req_t;

  // APB answer carrier
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rphp_apb_rsp_t;

  // Physical and link layer indications
  typedef struct packed {
    logic module_present;
    logic link_active;
  } rphp_phy_t;

endpackage : rphp_pkg

// [rtl/rphp_hotplug.sv]
// Hot-plug event logic of a root port: presence tracking, change flags,
// native interrupt, SYSTEM_CONTROL_IRQ status and SMI status with the SMI output.
// Assumes presence and link-active indications are synchronous to sys_clk.
// The clock enable gates every register, bus completion included.
//
// Behaviour
// - Presence changes and link-active changes are the hot-plug event sources.
// - A detected insertion sets presence_detect_state and presence_detect_changed.
// - A detected removal clears presence_detect_state and sets presence_detect_changed.
// - A presence event raises the native interrupt only with both irq enables set.
// - Enabled hot-plug events set hotplug_sci_status only while hotplug_sci_en is set.
// - Hot-plug events set SMI status bits only while hotplug_smi_en is set.
// - Under the SMI enable a presence change sets smi_presence_changed.
// - Under the SMI enable a link-active change sets smi_link_active_changed.
// - The SMI output is asserted while either SMI status bit is set.
// - SMI status bits set regardless of native interrupt or SYSTEM_CONTROL_IRQ enables.
// - SMI, SYSTEM_CONTROL_IRQ and the native interrupt may assert in the same cycle.
`timescale 1ns/100ps

module rphp_hotplug
  import rphp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  // APB slave
  input  wire rphp_pkg::rphp_apb_req_t apb_req,
  output      rphp_pkg::rphp_apb_rsp_t apb_rsp,
  // Physical and data link layer indications
  input  wire rphp_pkg::rphp_phy_t     phy_in,
  // Interrupt outputs
  output      logic                    hotplug_irq,
  output      logic                    system_control_irq,
  output      logic                    system_mgmt_irq_n,
  output      logic                    event_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [3:0]           ctrl_q;
  logic                 presence_detect_state_q;
  logic                 presence_detect_changed_q;
  logic                 hotplug_sci_status_q;
  logic                 smi_presence_changed_q;
  logic                 smi_link_active_changed_q;
  logic                 link_active_q;
  logic [INT_WIDTH-1:0] int_sts_q;
  logic [INT_WIDTH-1:0] int_mask_q;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  logic                 irq_q;
  logic                 cap_q;

  logic presence_change_irq_en;
  logic hotplug_irq_en;
  logic hotplug_sci_en;
  logic hotplug_smi_en;
  logic pres_evt;
  logic link_evt;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] wdat;
  logic apb_done;
  logic int_rd_done;
  logic [INT_WIDTH-1:0] int_evt;
  logic [INT_WIDTH-1:0] int_clr;

  // Register address match, used by both the write and read paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  ////////////////////////////////////////////////////////////////////////////
  // Field aliases and events

  assign presence_change_irq_en = ctrl_q[CTRL_PRES_IRQ_EN_BIT];
  assign hotplug_irq_en         = ctrl_q[CTRL_HP_IRQ_EN_BIT];
  assign hotplug_sci_en         = ctrl_q[CTRL_SCI_EN_BIT];
  assign hotplug_smi_en         = ctrl_q[CTRL_SMI_EN_BIT];

  // Any difference between the detected presence and the held state is an
  // insertion or a removal
  assign pres_evt = clk_en && (phy_in.module_present != presence_detect_state_q);
  // Link active compared with last cycle's sample, both directions
  assign link_evt = clk_en && (phy_in.link_active != link_active_q);

  // The access phase completes at the first enabled edge after the read data
  // was captured for this transfer; with the enable high this is zero wait.
  // A transfer whose setup edge fell in a stall waits one enabled edge more,
  // so read data is never stale and a write lands exactly once.
  assign apb_done    = clk_en && apb_req.psel && apb_req.penable && cap_q;
  assign apb_wr      = apb_done && apb_req.pwrite;
  assign apb_rd      = apb_done && !apb_req.pwrite;
  assign wdat        = apb_req.pwdata;
  assign int_rd_done = apb_rd && addr_is(apb_req.paddr, RPHP_INTSTS_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Control register; bits above the four enables are dropped and read zero

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_wr && addr_is(apb_req.paddr, RPHP_CTRL_OFS)) begin
      ctrl_q <= wdat[3:0];
    end
  end

  // Interrupt mask register
  // The mask only gates event_irq; the status bits record events regardless
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_mask_q <= MASK_RESET;
    end else if (apb_wr && addr_is(apb_req.paddr, RPHP_INTMSK_OFS)) begin
      int_mask_q <= wdat[INT_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presence state follows the physical layer detection
  // A short glitch on presence detect counts as a removal and a reinsertion;
  // debouncing is left to the physical layer

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presence_detect_state_q <= 1'b0;
    end else if (pres_evt) begin
      presence_detect_state_q <= phy_in.module_present;
    end
  end

  // Link active sample, one clock behind the indication
  // Resets low: a link already up at release is reported as a change
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_active_q <= 1'b0;
    end else if (clk_en) begin
      link_active_q <= phy_in.link_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky change flags; a set in the clearing cycle wins over the clear
  // Each flag has its own process so clearing one never disturbs another

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presence_detect_changed_q <= 1'b0;
    end else if (pres_evt) begin
      presence_detect_changed_q <= 1'b1;
    end else if (apb_wr && addr_is(apb_req.paddr, RPHP_STATUS_OFS)
                 && wdat[STS_PRES_CHANGED_BIT]) begin
      presence_detect_changed_q <= 1'b0;
    end
  end

  // SYSTEM_CONTROL_IRQ status: only enabled events, only with the SYSTEM_CONTROL_IRQ enable
  // Link events never reach SYSTEM_CONTROL_IRQ: only presence events have an enable of
  // their own, and SYSTEM_CONTROL_IRQ takes enabled events only
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hotplug_sci_status_q <= 1'b0;
    end else if (pres_evt && presence_change_irq_en && hotplug_sci_en) begin
      hotplug_sci_status_q <= 1'b1;
    end else if (apb_wr && addr_is(apb_req.paddr, RPHP_STATUS_OFS)
                 && wdat[STS_SCI_BIT]) begin
      hotplug_sci_status_q <= 1'b0;
    end
  end

  // SMI presence flag ignores native and SYSTEM_CONTROL_IRQ enables
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smi_presence_changed_q <= 1'b0;
    end else if (pres_evt && hotplug_smi_en) begin
      smi_presence_changed_q <= 1'b1;
    end else if (apb_wr && addr_is(apb_req.paddr, RPHP_STATUS_OFS)
                 && wdat[STS_SMI_PRES_BIT]) begin
      smi_presence_changed_q <= 1'b0;
    end
  end

  // SMI link-active flag
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smi_link_active_changed_q <= 1'b0;
    end else if (link_evt && hotplug_smi_en) begin
      smi_link_active_changed_q <= 1'b1;
    end else if (apb_wr && addr_is(apb_req.paddr, RPHP_STATUS_OFS)
                 && wdat[STS_SMI_LINK_BIT]) begin
      smi_link_active_changed_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event interrupt status, cleared by a read; a new event beats the read

  // Event vector and clear mask in interrupt status layout
  genvar gi;
  generate
    for (gi = 0; gi < INT_WIDTH; gi++) begin : g_int
      assign int_evt[gi] = (gi == INT_PRES_BIT) ? pres_evt : link_evt;
      // Only a bit that the read returned is cleared; an event that lands
      // between the data capture and the access edge stays pending
      assign int_clr[gi] = int_rd_done && prdata_q[gi];
    end
  endgenerate

  // One process owns the whole vector, so every bit has a single driver
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_sts_q <= '0;
    end else if (clk_en) begin
      int_sts_q <= int_evt | (int_sts_q & ~int_clr);
    end
  end

  // Level interrupt, registered
  // Registered so the pin is glitch free; it lags the status by one edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(int_sts_q & int_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the system; the four paths are independent

  // Native interrupt is a level while the change flag stands and both enables are on
  // A level, not a pulse, so enabling after the event still interrupts
  assign hotplug_irq = presence_detect_changed_q && presence_change_irq_en
                       && hotplug_irq_en;
  assign system_control_irq = hotplug_sci_status_q;
  // Active low; drops once both SMI flags are cleared
  assign system_mgmt_irq_n = !(smi_presence_changed_q || smi_link_active_changed_q);
  assign event_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Capture marker: set at the first enabled edge of a transfer, cleared
  // when it completes or when the master drops psel
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_q <= 1'b0;
    end else if (apb_done) begin
      cap_q <= 1'b0;
    end else if (clk_en) begin
      cap_q <= apb_req.psel;
    end
  end

  // APB read data, captured once per transfer at its first enabled edge,
  // normally the setup edge. Registering the mux keeps the read path off
  // the bus timing; the cost is that a read shows state one edge old.

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q  <= UNMAPPED_RD;
      pslverr_q <= 1'b0;
    end else if (clk_en && apb_req.psel && !cap_q) begin
      prdata_q  <= UNMAPPED_RD;
      pslverr_q <= 1'b0;
      case (apb_req.paddr)
        RPHP_CTRL_OFS: begin
          prdata_q[3:0] <= ctrl_q;
        end
        RPHP_STATUS_OFS: begin
          prdata_q[STS_PRES_STATE_BIT]   <= presence_detect_state_q;
          prdata_q[STS_PRES_CHANGED_BIT] <= presence_detect_changed_q;
          prdata_q[STS_SCI_BIT]          <= hotplug_sci_status_q;
          prdata_q[STS_SMI_PRES_BIT]     <= smi_presence_changed_q;
          prdata_q[STS_SMI_LINK_BIT]     <= smi_link_active_changed_q;
          prdata_q[STS_LINK_ACTIVE_BIT]  <= link_active_q;
        end
        RPHP_INTSTS_OFS: begin
          prdata_q[INT_WIDTH-1:0] <= int_sts_q;
        end
        RPHP_INTMSK_OFS: begin
          prdata_q[INT_WIDTH-1:0] <= int_mask_q;
        end
        default: begin
          pslverr_q <= 1'b1; // Unmapped address
        end
      endcase
    end
  end

  // Ready only in the access phase with data captured; low while stalled
  assign apb_rsp.pready  = apb_done;
  // Error only qualifies the access phase
  assign apb_rsp.pslverr = pslverr_q && apb_req.psel && apb_req.penable;
  assign apb_rsp.prdata  = prdata_q;

endmodule : rphp_hotplug

// [sim/rphp_hotplug_properties.sv]
// Checker for the hot-plug event block, bound to rphp_hotplug.
// Sees only top ports; enables and phy levels are shadowed here.
`timescale 1ns/100ps

module rphp_props
  import rphp_pkg::*;
(
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    sys_rst,
  input wire logic                    clk_en,
  // Bus and phy
  input wire rphp_pkg::rphp_apb_req_t apb_req,
  input wire rphp_pkg::rphp_apb_rsp_t apb_rsp,
  input wire rphp_pkg::rphp_phy_t     phy_in,
  // Interrupt outputs
  input wire logic                    hotplug_irq,
  input wire logic                    system_control_irq,
  input wire logic                    system_mgmt_irq_n,
  input wire logic                    event_irq
);
  logic [3:0] ctrl_q;
  logic       pres_q;
  logic       link_q;
  logic       acc;
  logic       ev_pres;
  logic       ev_link;
  logic       clr_smi;
  logic       xfer;
  logic       sci_cause;
  logic       smi_cause;

  // Event and access decode against the shadowed state
  assign acc     = clk_en & apb_req.psel & apb_req.penable;
  assign xfer    = acc & apb_rsp.pready;
  assign ev_pres = clk_en & (phy_in.module_present != pres_q);
  assign ev_link = clk_en & (phy_in.link_active != link_q);
  assign sci_cause = ctrl_q[0] & ctrl_q[2] & ev_pres;
  assign smi_cause = ctrl_q[3] & (ev_pres | ev_link);
  assign clr_smi = xfer & apb_req.pwrite & (apb_req.paddr == RPHP_STATUS_OFS)
                   & (|apb_req.pwdata[4:3]);

  // Shadow only moves on enabled edges, as the block does
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= 4'h0;
      pres_q <= 1'b0;
      link_q <= 1'b0;
    end else if (clk_en) begin
      pres_q <= phy_in.module_present;
      link_q <= phy_in.link_active;
      if (xfer && apb_req.pwrite && apb_req.paddr == RPHP_CTRL_OFS) begin
        ctrl_q <= apb_req.pwdata[3:0];
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_pres_smi;
    ev_pres && ctrl_q[3];
  endsequence
  sequence s_link_smi;
    ev_link && ctrl_q[3];
  endsequence

  a_irq_set: assert property (ev_pres && ctrl_q[1:0] == 2'b11 |=> hotplug_irq)
    else $error("native irq missing after presence change");
  a_irq_gate: assert property (hotplug_irq |-> ctrl_q[1:0] == 2'b11)
    else $error("native irq without both enables");
  a_sci_set: assert property (ev_pres && ctrl_q[0] && ctrl_q[2] |=> system_control_irq)
    else $error("sci status not set");
  a_sci_gate: assert property ($rose(system_control_irq)
      |-> $past(sci_cause))
    else $error("sci status set without enable");
  a_smi_pres: assert property (s_pres_smi |=> !system_mgmt_irq_n)
    else $error("smi missing after presence change");
  a_smi_link: assert property (s_link_smi |=> !system_mgmt_irq_n)
    else $error("smi missing after link change");
  a_smi_gate: assert property ($fell(system_mgmt_irq_n)
      |-> $past(smi_cause))
    else $error("smi raised without enabled event");
  a_smi_hold: assert property (!system_mgmt_irq_n && !clr_smi |=> !system_mgmt_irq_n)
    else $error("smi dropped without clear");
  a_apb_ready: assert property (acc && $past(clk_en) && $past(apb_req.psel)
      |-> apb_rsp.pready)
    else $error("no ready in access phase");
endmodule : rphp_props

bind rphp_hotplug rphp_props u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .phy_in(phy_in), .hotplug_irq(hotplug_irq),
  .system_control_irq(system_control_irq), .system_mgmt_irq_n(system_mgmt_irq_n),
  .event_irq(event_irq));

// [sim/rphp_slot_model.sv]
// Slot model: a hot-pluggable module whose link trains after insertion.
// Follows the bench's plug command; changes only after sys_clk edges.
`timescale 1ns/100ps

module rphp_slot_model
  import rphp_pkg::*;
(
  // Clock and command
  input  wire logic                sys_clk,
  input  wire logic                plug,
  input  wire logic [3:0]          train_cyc,
  // Levels towards the root port
  output      rphp_pkg::rphp_phy_t phy
);
  logic [3:0] cnt_q;

  // Link waits out train_cyc cycles after insertion; a removal drops presence and link at the same edge
  always_ff @(posedge sys_clk) begin
    phy.module_present <= plug;
    if (!plug) begin
      phy.link_active <= 1'b0;
      cnt_q           <= train_cyc;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      phy.link_active <= 1'b1;
    end
  end
endmodule : rphp_slot_model

// [sim/rphp_hotplug_test.sv]
// Self-checking bench for rphp_hotplug with the slot model.
// Waits out APB stalls from the random clock enable; assumes one clock domain.
`timescale 1ns/100ps

module rphp_hotplug_test;
  import rphp_pkg::*;
  logic          sys_clk, sys_rst, clk_en, plug, err;
  logic [3:0]    train, c;
  logic [1:0]    m;
  logic [31:0]   rd;
  rphp_apb_req_t apb_req;
  rphp_apb_rsp_t apb_rsp;
  rphp_phy_t     phy;
  logic          hp_irq, sci_irq, smi_n, ev_irq;
  int            n_errors, checks, seed;
  logic [3:0]    corner [4] = '{4'h8, 4'hF, 4'h5, 4'h0};

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  // Random stalls stretch bus waits and event sampling
  always @(posedge sys_clk) clk_en <= ($random(seed) % 6) != 0;

  rphp_hotplug uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .phy_in(phy), .hotplug_irq(hp_irq),
    .system_control_irq(sci_irq), .system_mgmt_irq_n(smi_n), .event_irq(ev_irq));
  rphp_slot_model slot (.sys_clk(sys_clk), .plug(plug), .train_cyc(train), .phy(phy));

  task automatic final_report();
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits on pready, idles one cycle after
  // Only the watchdog ends a wait that never sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic done;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      // Mid-cycle look: these values stand at the coming rising edge
      @(negedge sys_clk);
      done = apb_rsp.pready;
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      @(posedge sys_clk);
    end while (done !== 1'b1);
    apb_req <= '0;
    @(posedge sys_clk);
  endtask : apb

  // Status after one plug toggle under enables e
  function automatic logic [31:0] exp_sts(logic p, logic [3:0] e);
    return {26'h0, p, e[3], e[3], e[0] & e[2], 1'b1, p};
  endfunction : exp_sts

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    seed = 46462;
    sys_rst = 1'b1;
    plug = 1'b0;
    train = 4'h0;
    apb_req = '0;
    n_errors = 0;
    checks = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
      chk(err, i == 4);
    end
    for (int i = 0; i < 10; i++) begin
      c = (i < 4) ? corner[i] : 4'($random(seed));
      m = 2'($random(seed));
      train <= 4'($random(seed));
      apb(1'b1, RPHP_CTRL_OFS, {28'h0, c});
      apb(1'b1, RPHP_INTMSK_OFS, {30'h0, m});
      plug <= ~plug;
      repeat (40) @(posedge sys_clk);
      apb(1'b0, RPHP_STATUS_OFS, 32'h0);
      chk(rd, exp_sts(plug, c));
      chk(hp_irq, c[0] & c[1]);
      chk(sci_irq, c[0] & c[2]);
      chk(smi_n, !c[3]);
      chk(ev_irq, |m);
      apb(1'b0, RPHP_INTSTS_OFS, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, RPHP_STATUS_OFS, 32'h1E);
      repeat (2) @(posedge sys_clk);
      chk({hp_irq, sci_irq, smi_n, ev_irq}, 4'b0010);
    end
    final_report();
  end
endmodule : rphp_hotplug_test
